// file: rtl/dcrms_core.sv
// Deflection controller register bank with two-wire slave and mode sequencer
// What this block does
// - Protection may clear or force power bits
// - No acknowledge while power-on clear active
// - After clear: standby, start values, unlock high
// - Standby off: supply on, only vertical runs
// - Ignore soft-start set below upper threshold
// - Each write address, subaddress, then data bytes, no increment
// - Soft start ramps drives, enables both loops
// - Running: unlock low when sync loop locked
// - Running writes act immediately
// - Soft-start clear, supply dip, protection or power-on clear leave operation
// - Soft-down: supply drive first, then horizontal
// - Protection floats drives, blanks, keeps registers
// - Protection exits: standby, restart, or low supply
// - Standby floats drivers, loses other registers
// - Upper dip: soft-down then automatic soft start
// - Lower dip: drivers off at once, standby
// - Vertical moire D2..D0 at 03, moire gated
// - Horizontal moire D4..D0 at 05, moire gated
// - Linearity balance D6..D3 at 03, centrable
// - Corner field D4..D0 at 09, centrable
// - Horizontal position all bits of 06
// - Address 8C only; data repeats same subaddress
`timescale 1ns/1ps
module dcrms_core (
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_oe,
  input  wire logic              i_por_active,
  input  wire logic              i_supply_below_upper,
  input  wire logic              i_supply_below_lower,
  input  wire logic              i_protect_fault,
  input  wire logic              i_sync_loop_locked,
  output dcrms_pkg::dcrms_adj_t  o_adj,
  output dcrms_pkg::dcrms_drv_t  o_drv,
  output logic                   o_unlock_out,
  output logic                   o_unlock_oe,
  output logic                   o_clamp_blank_continuous,
  output logic                   o_protect_mode
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_ff <= 7'h7F;
      sync2_ff <= 7'h7F;
    end else begin
      sync1_ff <= {i_scl, i_sda, i_por_active, i_supply_below_upper,
                   i_supply_below_lower, i_protect_fault, i_sync_loop_locked};
      sync2_ff <= sync1_ff;
    end
  end
  logic scl_s, sda_s, por_s, below_up_s, below_lo_s, fault_s, locked_s;
  assign {scl_s, sda_s, por_s, below_up_s, below_lo_s, fault_s, locked_s} = sync2_ff;

  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ---------------------------------------------------------------
  // Two-wire slave: address, subaddress, data bytes
  // ---------------------------------------------------------------
  logic       active_ff;
  logic [1:0] phase_ff;   // 0 address, 1 subaddress, 2 data
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] subaddr_ff;
  logic       ack_ff;
  logic       wr_pulse_ff;
  logic [7:0] wr_data_ff;

  // Bits are taken on the synchronised SCL rise, so each bus clock phase must
  // last several system clocks; the bus is meant to run far below i_clk
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_ff   <= 1'b0;
      phase_ff    <= 2'd0;
      bitcnt_ff   <= 4'h0;
      shift_ff    <= 8'h00;
      subaddr_ff  <= 8'h00;
      ack_ff      <= 1'b0;
      wr_pulse_ff <= 1'b0;
      wr_data_ff  <= 8'h00;
    end else begin
      wr_pulse_ff <= 1'b0;
      if (por_s || bus_stop) begin
        active_ff <= 1'b0;
        ack_ff    <= 1'b0;
      end else if (bus_start) begin
        active_ff <= 1'b1;
        phase_ff  <= 2'd0;
        bitcnt_ff <= 4'h0;
        ack_ff    <= 1'b0;
      end else if (active_ff && scl_rise && bitcnt_ff < 4'h8) begin
        shift_ff  <= {shift_ff[6:0], sda_s};
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end else if (active_ff && scl_fall) begin
        if (bitcnt_ff == 4'h8 && !ack_ff) begin
          unique case (phase_ff)
            2'd0: begin
              if (shift_ff == dcrms_pkg::DEVICE_BUS_ADDRESS) begin
                ack_ff <= 1'b1;
              end else begin
                active_ff <= 1'b0;
              end
            end
            2'd1: begin
              subaddr_ff <= shift_ff;
              ack_ff     <= 1'b1;
            end
            default: begin
              // Repeated data bytes land on the same subaddress
              wr_data_ff  <= shift_ff;
              wr_pulse_ff <= 1'b1;
              ack_ff      <= 1'b1;
            end
          endcase
        end else if (ack_ff) begin
          ack_ff    <= 1'b0;
          bitcnt_ff <= 4'h0;
          if (phase_ff != 2'd2) begin
            phase_ff <= phase_ff + 2'd1;
          end
        end
      end
    end
  end
  // Masked directly as well, so a power-on clear arriving mid-byte frees SDA
  // without waiting for the acknowledge register to drop
  assign o_sda_oe = ack_ff & ~por_s;

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  dcrms_pkg::dcrms_mode_t mode_ff;
  logic       standby_ff;
  logic       soft_start_release_bit_ff;
  logic       protect_ff;
  logic       auto_restart_ff;
  logic [7:0] hduty_ff;
  logic [7:0] bduty_ff;
  logic [$clog2(dcrms_pkg::RAMP_CYC+1)-1:0] tick_cnt_ff;
  logic ramp_tick;
  assign ramp_tick = (tick_cnt_ff == '0);
  // One free-running tick paces both ramps, so a ramp may start up to one step late

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_ff <= '0;
    end else if (ramp_tick) begin
      tick_cnt_ff <= ($bits(tick_cnt_ff))'(dcrms_pkg::RAMP_CYC - 1);
    end else begin
      tick_cnt_ff <= tick_cnt_ff - 1'b1;
    end
  end

  logic pwr_write;
  assign pwr_write = wr_pulse_ff && subaddr_ff == dcrms_pkg::SA_POWER;

  // Priority: power-on clear, lower dip, protection entry, then host writes;
  // a supply collapse must win over any bus write landing in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ff         <= dcrms_pkg::DCRMS_POR;
      standby_ff      <= dcrms_pkg::STANDBY_START;
      soft_start_release_bit_ff       <= dcrms_pkg::SOFTSTART_START;
      protect_ff      <= 1'b0;
      auto_restart_ff <= 1'b0;
      hduty_ff        <= dcrms_pkg::DUTY_MIN;
      bduty_ff        <= dcrms_pkg::DUTY_MIN;
    end else if (por_s) begin
      mode_ff    <= dcrms_pkg::DCRMS_POR;
      standby_ff <= dcrms_pkg::STANDBY_START;
      soft_start_release_bit_ff  <= dcrms_pkg::SOFTSTART_START;
      protect_ff <= 1'b0;
      hduty_ff   <= dcrms_pkg::DUTY_MIN;
      bduty_ff   <= dcrms_pkg::DUTY_MIN;
    end else if (below_lo_s) begin
      // Any mode, drivers cut without ramp
      mode_ff         <= dcrms_pkg::DCRMS_STANDBY;
      standby_ff      <= 1'b1;
      soft_start_release_bit_ff       <= 1'b0;
      protect_ff      <= 1'b0;
      auto_restart_ff <= 1'b0;
      hduty_ff        <= dcrms_pkg::DUTY_MIN;
      bduty_ff        <= dcrms_pkg::DUTY_MIN;
    end else if (fault_s && !protect_ff) begin
      protect_ff <= 1'b1;
      soft_start_release_bit_ff  <= 1'b0;
      mode_ff    <= dcrms_pkg::DCRMS_IDLE;
      hduty_ff   <= dcrms_pkg::DUTY_MIN;
      bduty_ff   <= dcrms_pkg::DUTY_MIN;
    end else begin
      if (pwr_write) begin
        standby_ff <= wr_data_ff[dcrms_pkg::PWR_STANDBY];
        if (!(below_up_s && wr_data_ff[dcrms_pkg::PWR_SOFTSTART])) begin
          soft_start_release_bit_ff <= wr_data_ff[dcrms_pkg::PWR_SOFTSTART];
        end
      end
      unique case (mode_ff)
        dcrms_pkg::DCRMS_POR: begin
          mode_ff <= dcrms_pkg::DCRMS_STANDBY;
        end
        dcrms_pkg::DCRMS_STANDBY: begin
          if (!standby_ff) begin
            mode_ff <= dcrms_pkg::DCRMS_IDLE;
          end
        end
        dcrms_pkg::DCRMS_IDLE: begin
          if (protect_ff && !soft_start_release_bit_ff && standby_ff) begin
            protect_ff <= 1'b0;
            mode_ff    <= dcrms_pkg::DCRMS_STANDBY;
          end else if (soft_start_release_bit_ff && !below_up_s) begin
            protect_ff <= 1'b0;
            mode_ff    <= dcrms_pkg::DCRMS_SOFTUP;
          end else if (standby_ff && !protect_ff) begin
            mode_ff <= dcrms_pkg::DCRMS_STANDBY;
          end
        end
        dcrms_pkg::DCRMS_SOFTUP: begin
          if (!soft_start_release_bit_ff || below_up_s) begin
            auto_restart_ff <= below_up_s;
            mode_ff         <= dcrms_pkg::DCRMS_SOFTDN;
          end else if (ramp_tick) begin
            // Ramp both duty cycles up together
            if (hduty_ff != dcrms_pkg::DUTY_MAX) begin
              hduty_ff <= hduty_ff + 8'h01;
            end
            if (bduty_ff != dcrms_pkg::DUTY_MAX) begin
              bduty_ff <= bduty_ff + 8'h01;
            end
            if (hduty_ff == dcrms_pkg::DUTY_MAX && bduty_ff == dcrms_pkg::DUTY_MAX) begin
              mode_ff <= dcrms_pkg::DCRMS_RUN;
            end
          end
        end
        dcrms_pkg::DCRMS_RUN: begin
          if (!soft_start_release_bit_ff || below_up_s) begin
            auto_restart_ff <= below_up_s;
            mode_ff         <= dcrms_pkg::DCRMS_SOFTDN;
          end
        end
        dcrms_pkg::DCRMS_SOFTDN: begin
          if (ramp_tick) begin
            // Supply drive falls fully before horizontal drive
            if (bduty_ff != dcrms_pkg::DUTY_MIN) begin
              bduty_ff <= bduty_ff - 8'h01;
            end else if (hduty_ff != dcrms_pkg::DUTY_MIN) begin
              hduty_ff <= hduty_ff - 8'h01;
            end else if (auto_restart_ff) begin
              if (!below_up_s) begin
                auto_restart_ff <= 1'b0;
                mode_ff         <= dcrms_pkg::DCRMS_SOFTUP;
              end
            end else begin
              mode_ff <= dcrms_pkg::DCRMS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Adjustment registers
  // ---------------------------------------------------------------
  // Kept across protection; cleared in standby since contents are lost
  // The power byte is mirrored here only; its bits live in the sequencer so
  // that the standby clear cannot wipe them
  logic [7:0] regs_ff [0:15];
  logic       in_standby;
  assign in_standby = (mode_ff == dcrms_pkg::DCRMS_STANDBY) || (mode_ff == dcrms_pkg::DCRMS_POR);

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_reg
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          regs_ff[g] <= 8'h00;
        end else if (in_standby) begin
          regs_ff[g] <= 8'h00;
        end else if (wr_pulse_ff && subaddr_ff == 8'(g)) begin
          regs_ff[g] <= wr_data_ff;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Field extraction with switch gating
  // ---------------------------------------------------------------
  logic [7:0] sw1, sw2;
  assign sw1 = regs_ff[dcrms_pkg::SA_SWITCH1[3:0]];
  assign sw2 = regs_ff[dcrms_pkg::SA_SWITCH2[3:0]];

  always_comb begin
    // Don't-care bits are dropped by the slices below
    o_adj.horizontal_size           = regs_ff[dcrms_pkg::SA_HSIZE[3:0]];
    o_adj.vertical_position_field   = sw2[dcrms_pkg::SW2_POSTRAP_CENTRE] ? dcrms_pkg::CENTRE7
                                      : regs_ff[dcrms_pkg::SA_VERTICAL_POSITION[3:0]][7:1];
    o_adj.vertical_linearity_balance_field = sw2[dcrms_pkg::SW2_LINBAL_CENTRE] ? dcrms_pkg::CENTRE4
                                      : regs_ff[dcrms_pkg::SA_VLBMOI[3:0]][6:3];
    o_adj.vertical_moire_field      = sw1[dcrms_pkg::SW1_MOIRE_DIS] ? 3'h0
                                      : regs_ff[dcrms_pkg::SA_VLBMOI[3:0]][2:0];
    o_adj.pincushion_field          = regs_ff[dcrms_pkg::SA_PIN[3:0]][5:0];
    o_adj.horizontal_moire_field    = sw1[dcrms_pkg::SW1_MOIRE_DIS] ? 5'h00
                                      : regs_ff[dcrms_pkg::SA_HMOI[3:0]][4:0];
    o_adj.horizontal_position_field = regs_ff[dcrms_pkg::SA_HPOSN[3:0]];
    o_adj.vertical_linearity_field  = sw1[dcrms_pkg::SW1_LINCOR_CENTRE] ? dcrms_pkg::CENTRE4
                                      : regs_ff[dcrms_pkg::SA_VLINPB[3:0]][7:4];
    o_adj.pin_balance_field         = regs_ff[dcrms_pkg::SA_VLINPB[3:0]][3:0];
    o_adj.vertical_size_field       = regs_ff[dcrms_pkg::SA_VSZ[3:0]][7:1];
    o_adj.corner_correction_field   = sw1[dcrms_pkg::SW1_LINCOR_CENTRE] ? dcrms_pkg::CENTRE5
                                      : regs_ff[dcrms_pkg::SA_CORNER[3:0]][4:0];
    o_adj.focus_parabola_field      = regs_ff[dcrms_pkg::SA_FOCUS[3:0]][7:5];
    o_adj.trapezium_field           = sw2[dcrms_pkg::SW2_POSTRAP_CENTRE] ? dcrms_pkg::CENTRE4
                                      : regs_ff[dcrms_pkg::SA_TRAPPAR[3:0]][7:4];
    o_adj.parallelogram_field       = regs_ff[dcrms_pkg::SA_TRAPPAR[3:0]][3:0];
  end

  // ---------------------------------------------------------------
  // Driver and status outputs
  // ---------------------------------------------------------------
  logic drives_on, running;
  assign drives_on = (mode_ff == dcrms_pkg::DCRMS_SOFTUP) || (mode_ff == dcrms_pkg::DCRMS_RUN)
                   || (mode_ff == dcrms_pkg::DCRMS_SOFTDN);
  assign running   = (mode_ff == dcrms_pkg::DCRMS_RUN);

  // Enables decode from the mode and the protection flag alone, so a lower dip cuts the drivers on the
  // same edge that the mode register leaves the ramp states
  always_comb begin
    o_drv.horizontal_drive_output_duty          = hduty_ff;
    o_drv.supply_drive_output_duty          = bduty_ff;
    o_drv.horizontal_drive_output_en            = drives_on & ~protect_ff;
    o_drv.supply_drive_output_en            = drives_on & ~protect_ff;
    o_drv.vout_en            = ~in_standby & ~protect_ff;
    o_drv.loops_en           = drives_on & ~protect_ff;
    o_drv.internal_supply_en = ~in_standby;
  end

  // Unlock stays driven high through standby so the host reads unlocked rather
  // than a floating pin; only protection lets it float
  assign o_unlock_out             = ~(running & locked_s);
  assign o_unlock_oe              = ~protect_ff & ~in_standby | (mode_ff == dcrms_pkg::DCRMS_POR)
                                    | (mode_ff == dcrms_pkg::DCRMS_STANDBY);
  assign o_clamp_blank_continuous = protect_ff;
  assign o_protect_mode           = protect_ff;

endmodule

// file: inc/dcrms_pkg.sv
// Package: subaddresses, field layouts, bus address and mode states of the deflection control bank
package dcrms_pkg;

  // ---------------------------------------------------------------
  // Bus addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] DEVICE_BUS_ADDRESS = 8'h8C;

  // ---------------------------------------------------------------
  // Subaddresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SA_HSIZE   = 8'h00;
  localparam logic [7:0] SA_SWITCH1 = 8'h01;
  localparam logic [7:0] SA_VERTICAL_POSITION    = 8'h02;
  localparam logic [7:0] SA_VLBMOI  = 8'h03;
  localparam logic [7:0] SA_PIN     = 8'h04;
  localparam logic [7:0] SA_HMOI    = 8'h05;
  localparam logic [7:0] SA_HPOSN   = 8'h06;
  localparam logic [7:0] SA_VLINPB  = 8'h07;
  localparam logic [7:0] SA_VSZ     = 8'h08;
  localparam logic [7:0] SA_CORNER  = 8'h09;
  localparam logic [7:0] SA_FOCUS   = 8'h0A;
  localparam logic [7:0] SA_SWITCH2 = 8'h0B;
  localparam logic [7:0] SA_TRAPPAR = 8'h0C;
  localparam logic [7:0] SA_POWER   = 8'h0D;

  // ---------------------------------------------------------------
  // Switch and power bit positions
  // ---------------------------------------------------------------
  localparam int SW1_LINCOR_CENTRE = 4;
  localparam int SW1_MOIRE_DIS     = 5;
  localparam int SW2_LINBAL_CENTRE = 5;
  localparam int SW2_POSTRAP_CENTRE = 6;
  localparam int PWR_STANDBY       = 0;
  localparam int PWR_SOFTSTART     = 1;

  // ---------------------------------------------------------------
  // Start values and centre codes
  // ---------------------------------------------------------------
  localparam logic       STANDBY_START   = 1'b1;
  localparam logic       SOFTSTART_START = 1'b0;
  localparam logic [3:0] CENTRE4         = 4'h8;
  localparam logic [4:0] CENTRE5         = 5'h10;
  localparam logic [6:0] CENTRE7         = 7'h40;

  // ---------------------------------------------------------------
  // Soft ramp
  // ---------------------------------------------------------------
  localparam int          RAMP_STEP_NS = 1000;
  localparam int          CLK_NS       = 10;
  localparam int          RAMP_CYC     = RAMP_STEP_NS / CLK_NS;
  localparam logic [7:0]  DUTY_MAX     = 8'hFF;
  localparam logic [7:0]  DUTY_MIN     = 8'h00;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    DCRMS_POR     = 6'b000001,
    DCRMS_STANDBY = 6'b000010,
    DCRMS_IDLE    = 6'b000100,
    DCRMS_SOFTUP  = 6'b001000,
    DCRMS_RUN     = 6'b010000,
    DCRMS_SOFTDN  = 6'b100000
  } dcrms_mode_t;

  // Adjustment fields as applied to the analogue section
  typedef struct packed {
    logic [7:0] horizontal_size;
    logic [6:0] vertical_position_field;
    logic [3:0] vertical_linearity_balance_field;
    logic [2:0] vertical_moire_field;
    logic [5:0] pincushion_field;
    logic [4:0] horizontal_moire_field;
    logic [7:0] horizontal_position_field;
    logic [3:0] vertical_linearity_field;
    logic [3:0] pin_balance_field;
    logic [6:0] vertical_size_field;
    logic [4:0] corner_correction_field;
    logic [2:0] focus_parabola_field;
    logic [3:0] trapezium_field;
    logic [3:0] parallelogram_field;
  } dcrms_adj_t;

  // Driver stage controls
  typedef struct packed {
    logic [7:0] horizontal_drive_output_duty;
    logic [7:0] supply_drive_output_duty;
    logic       horizontal_drive_output_en;
    logic       supply_drive_output_en;
    logic       vout_en;
    logic       loops_en;
    logic       internal_supply_en;
  } dcrms_drv_t;

endpackage

// file: dv/dcrms_properties.sv
// Checker: port-level timing and mode properties of the deflection control bank
`timescale 1ns/1ps
module dcrms_properties (
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  input wire logic                  i_scl,
  input wire logic                  i_por_active,
  input wire logic                  i_supply_below_lower,
  input wire logic                  o_sda_oe,
  input wire dcrms_pkg::dcrms_drv_t o_drv,
  input wire logic                  o_unlock_out,
  input wire logic                  o_unlock_oe,
  input wire logic                  o_clamp_blank_continuous,
  input wire logic                  o_protect_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Input synchroniser lag is covered by the three-deep history
  por_no_ack_a: assert property (i_por_active && $past(i_por_active, 3) |-> !o_sda_oe)
    else $error("acknowledge during power-on clear");
  ack_scl_low_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("acknowledge raised while bus clock high");
  protect_outputs_a: assert property (o_protect_mode |-> o_clamp_blank_continuous && !o_unlock_oe
    && !o_drv.horizontal_drive_output_en && !o_drv.supply_drive_output_en && !o_drv.loops_en)
    else $error("protection outputs wrong");
  unlock_lock_a: assert property (o_unlock_oe && !o_unlock_out |-> o_drv.loops_en)
    else $error("unlock low outside operation");
  unlock_high_a: assert property (o_unlock_oe && !o_drv.loops_en |-> o_unlock_out)
    else $error("unlock low while loops off");
  lower_dip_a: assert property ($rose(i_supply_below_lower) |-> ##[0:4]
    (!o_drv.horizontal_drive_output_en && !o_drv.supply_drive_output_en && !o_drv.internal_supply_en))
    else $error("drivers not cut on lower dip");
  standby_float_a: assert property (!o_drv.internal_supply_en |->
    !o_drv.vout_en && !o_drv.horizontal_drive_output_en && !o_drv.supply_drive_output_en)
    else $error("driver enabled in standby");
  idle_drivers_a: assert property (!o_drv.loops_en |-> !o_drv.horizontal_drive_output_en && !o_drv.supply_drive_output_en)
    else $error("drive enabled without loops");
  softdn_order_a: assert property (o_drv.internal_supply_en && o_drv.horizontal_drive_output_duty < $past(o_drv.horizontal_drive_output_duty)
    |-> o_drv.supply_drive_output_duty == 8'h00)
    else $error("horizontal duty fell before supply duty");
endmodule

bind dcrms_core dcrms_properties i_dcrms_properties (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_por_active(i_por_active),
  .i_supply_below_lower(i_supply_below_lower), .o_sda_oe(o_sda_oe), .o_drv(o_drv),
  .o_unlock_out(o_unlock_out), .o_unlock_oe(o_unlock_oe),
  .o_clamp_blank_continuous(o_clamp_blank_continuous), .o_protect_mode(o_protect_mode));

// file: dv/dcrms_host_model.sv
// Host bus master model writing the control bank over the two-wire bus
`timescale 1ns/1ps
module dcrms_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Quarter bit period; keeps the clock low phase above the slave's minimum
  localparam int QTR = 4;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic bit_cycle(input logic b, output logic seen);
    o_sda_low <= !b;
    tick(QTR);
    o_scl <= 1'b1;
    tick(QTR);
    seen = i_sda;
    tick(QTR);
    o_scl <= 1'b0;
    tick(QTR);
  endtask
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(v[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask
  // Abandons the frame at once when the address is refused
  task automatic write(input logic [7:0] adr, input logic [7:0] sa, input logic [7:0] d0,
                       input logic [7:0] d1, input int n, output logic acked);
    logic a;
    acked = 1'b0;
    o_sda_low <= 1'b1;
    tick(QTR);
    o_scl <= 1'b0;
    tick(QTR);
    send_byte(adr, a);
    if (a) begin
      acked = 1'b1;
      send_byte(sa, a);
      send_byte(d0, a);
      if (n > 1) send_byte(d1, a);
    end
    o_sda_low <= 1'b1;
    tick(QTR);
    o_scl <= 1'b1;
    tick(QTR);
    o_sda_low <= 1'b0;
    tick(QTR);
  endtask
endmodule

// file: dv/dcrms_tb_top.sv
// Testbench: host model, reference register image and scenario sequence
`timescale 1ns/1ps
module dcrms_tb_top;
  logic                  clk = 1'b0;
  logic                  arst_n, por, bu, bl, flt, lck, scl, hl, a;
  logic [7:0]            lfsr;
  logic [7:0]            sh [16];
  logic [7:0]            sas [6] = '{8'h01, 8'h0B, 8'h03, 8'h05, 8'h06, 8'h09};
  int                    failures = 0;
  int                    tests_run = 0;
  wire                   sda_oe;
  wire                   sda = !(hl | sda_oe);
  dcrms_pkg::dcrms_adj_t o_adj;
  dcrms_pkg::dcrms_drv_t o_drv;
  logic                  o_unlock_out, o_protect_mode, o_blank, unlock_oe;

  always #5 clk = !clk;

  dcrms_core i_dcrms_core (.i_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe),
    .i_por_active(por), .i_supply_below_upper(bu), .i_supply_below_lower(bl), .i_protect_fault(flt),
    .i_sync_loop_locked(lck), .o_adj(o_adj), .o_drv(o_drv), .o_unlock_out(o_unlock_out),
    .o_unlock_oe(unlock_oe), .o_clamp_blank_continuous(o_blank), .o_protect_mode(o_protect_mode));
  dcrms_host_model i_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(hl));

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] sa, input logic [7:0] d, input logic [7:0] exp_ack);
    logic k;
    i_host.write(dcrms_pkg::DEVICE_BUS_ADDRESS, sa, d, d, 1, k);
    chk({7'h00, k}, exp_ack);
    if (k) sh[sa[3:0]] = d;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  // Reference view of the gated moire, linearity-balance and corner fields and the ungated horizontal position
  task automatic chk_adj;
    chk(8'(o_adj.vertical_moire_field), sh[1][5] ? 8'h00 : {5'h00, sh[3][2:0]});
    chk(8'(o_adj.horizontal_moire_field), sh[1][5] ? 8'h00 : {3'h0, sh[5][4:0]});
    chk(8'(o_adj.vertical_linearity_balance_field), sh[11][5] ? 8'h08 : {4'h0, sh[3][6:3]});
    chk(8'(o_adj.corner_correction_field), sh[1][4] ? 8'h10 : {3'h0, sh[9][4:0]});
    chk(o_adj.horizontal_position_field, sh[6]);
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatched %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test;
  end

  initial begin
    {arst_n, bl, flt, lck} = 4'h0;
    {por, bu} = 2'b11;
    lfsr = 8'h41;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    wr(8'h06, 8'h5A, 8'h00);
    @(posedge clk);
    por <= 1'b0;
    repeat (8) @(negedge clk);
    chk({o_unlock_out, o_drv.internal_supply_en, unlock_oe}, 8'h05);
    i_host.write(8'h8E, 8'h06, 8'h11, 8'h11, 1, a);
    chk({7'h00, a}, 8'h00);
    $display("power-on test done");
    wr(8'h0D, 8'h02, 8'h01);
    chk({o_drv.internal_supply_en, o_drv.vout_en, o_drv.horizontal_drive_output_en, o_unlock_out}, 8'h0D);
    repeat (6) begin
      for (int k = 0; k < 6; k++) begin
        lfsr = lfsr_next(lfsr);
        wr(sas[k], lfsr, 8'h01);
      end
      chk_adj;
    end
    lfsr = lfsr_next(lfsr);
    i_host.write(dcrms_pkg::DEVICE_BUS_ADDRESS, 8'h06, 8'h33, lfsr, 2, a);
    sh[6] = lfsr;
    repeat (4) @(negedge clk);
    chk_adj;
    $display("register test done");
    @(posedge clk);
    bu <= 1'b0;
    repeat (20) @(posedge clk);
    wr(8'h0D, 8'h02, 8'h01);
    for (int n = 0; n < 30000 && !(o_drv.horizontal_drive_output_duty === 8'hFF && o_drv.supply_drive_output_duty === 8'hFF); n++) @(negedge clk);
    chk({o_drv.loops_en, o_drv.horizontal_drive_output_en, o_drv.supply_drive_output_en}, 8'h07);
    chk(o_drv.horizontal_drive_output_duty & o_drv.supply_drive_output_duty, 8'hFF);
    @(posedge clk);
    lck <= 1'b1;
    // Full operation begins one ramp step after both duties reach their top
    repeat (dcrms_pkg::RAMP_CYC + 8) @(negedge clk);
    chk({7'h00, o_unlock_out}, 8'h00);
    lfsr = lfsr_next(lfsr);
    wr(8'h06, lfsr, 8'h01);
    chk_adj;
    @(posedge clk);
    bu <= 1'b1;
    repeat (300) @(negedge clk);
    chk({7'h00, o_drv.horizontal_drive_output_en && o_drv.supply_drive_output_duty != 8'hFF}, 8'h01);
    chk(o_drv.horizontal_drive_output_duty, 8'hFF);
    @(posedge clk);
    bu <= 1'b0;
    wr(8'h0D, 8'h00, 8'h01);
    repeat (400) @(negedge clk);
    chk({7'h00, o_drv.supply_drive_output_duty != 8'hFF}, 8'h01);
    chk(o_drv.horizontal_drive_output_duty, 8'hFF);
    $display("soft start test done");
    @(posedge clk);
    bl <= 1'b1;
    bu <= 1'b1;
    repeat (6) @(negedge clk);
    chk({o_drv.horizontal_drive_output_en, o_drv.internal_supply_en}, 8'h00);
    foreach (sh[i]) sh[i] = 8'h00;
    chk_adj;
    @(posedge clk);
    {bl, bu} <= 2'b00;
    repeat (6) @(posedge clk);
    wr(8'h0D, 8'h00, 8'h01);
    wr(8'h06, 8'hA7, 8'h01);
    @(posedge clk);
    flt <= 1'b1;
    repeat (6) @(negedge clk);
    chk({o_protect_mode, o_blank, unlock_oe}, 8'h06);
    chk_adj;
    @(posedge clk);
    flt <= 1'b0;
    wr(8'h0D, 8'h01, 8'h01);
    chk({o_protect_mode, o_drv.internal_supply_en}, 8'h00);
    $display("protection test done");
    stop_test;
  end
endmodule
